// File: logic/pin_cell.sv
// One multiplexed pin: GPIO or peripheral ownership, with input synchroniser.
// Assumes the pin level may change at any time relative to clk.
`timescale 1ns/100ps
module pin_cell (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Selection
   input wire logic func_sel,
   input wire logic gpio_dir,
   input wire logic gpio_out,
   input wire logic periph_out,
   input wire logic periph_oe,
   // Pin
   input wire logic pin_in,
   output logic pin_out,
   output logic pin_oe,
   // Synchronised pin level
   output logic pin_level
);
   logic meta_q;
   logic sync_q;
   logic out_d;
   logic oe_d;
   logic out_q;
   logic oe_q;

   always_comb begin
      if (func_sel) begin
         out_d = periph_out;
         oe_d = periph_oe;
      end else begin
         out_d = gpio_out;
         oe_d = gpio_dir;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         out_q <= 1'b0;
         oe_q <= 1'b0;
      end else begin
         meta_q <= pin_in;
         sync_q <= meta_q;
         out_q <= out_d;
         oe_q <= oe_d;
      end
   end

   assign pin_out = out_q;
   assign pin_oe = oe_q;
   assign pin_level = sync_q;

   chk_periph_owns_dir: assert property (@(posedge clk) disable iff (!arst_n)
      func_sel |=> (pin_oe == $past(periph_oe)))
      else $error("Peripheral direction not followed");
   chk_gpio_owns_dir: assert property (@(posedge clk) disable iff (!arst_n)
      !func_sel |=> (pin_oe == $past(gpio_dir)))
      else $error("GPIO direction not followed");
endmodule : pin_cell

// File: logic/serial_pin_mux.sv
// Pin multiplexer for the sync and async serial ports on ports D and E.
// Assumes an APB master on REF_CLK; serial engines sit outside on PERIPH ports.
`timescale 1ns/100ps
module serial_pin_mux
   import serial_pin_mux_pkg::*;
(
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic ARST_N,
   // APB slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // Port D pins
   input wire logic [PORTD_WIDTH-1:0] PORTD_IN,
   output logic [PORTD_WIDTH-1:0] PORTD_OUT,
   output logic [PORTD_WIDTH-1:0] PORTD_OE,
   // Port E pins
   input wire logic [PORTE_WIDTH-1:0] PORTE_IN,
   output logic [PORTE_WIDTH-1:0] PORTE_OUT,
   output logic [PORTE_WIDTH-1:0] PORTE_OE,
   // Synchronous serial engine
   input wire sync_port_drive_type SYNC_DRIVE,
   output sync_port_sense_type SYNC_SENSE,
   // Asynchronous serial engine
   input wire async_port_drive_type ASYNC_DRIVE,
   output async_port_sense_type ASYNC_SENSE
);
   // ==========================================
   // Registers
   logic [PORTD_WIDTH-1:0] d_func_q, d_func_d;
   logic [PORTD_WIDTH-1:0] d_dir_q, d_dir_d;
   logic [PORTD_WIDTH-1:0] d_data_q, d_data_d;
   logic [PORTE_WIDTH-1:0] e_func_q, e_func_d;
   logic [PORTE_WIDTH-1:0] e_dir_q, e_dir_d;
   logic [PORTE_WIDTH-1:0] e_data_q, e_data_d;
   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pready_d;
   logic pslverr_q, pslverr_d;
   logic access;
   logic mapped;

   // Pin-cell wiring
   logic [PORTD_WIDTH-1:0] d_per_out, d_per_oe, d_level;
   logic [PORTE_WIDTH-1:0] e_per_out, e_per_oe, e_level;

   // Sync clock watchdog state
   logic sck_prev_q, sck_prev_d;
   logic [HALF_COUNT_WIDTH-1:0] half_cnt_q, half_cnt_d;
   logic short_half_q, short_half_d;

   assign access = PSEL && PENABLE && !pready_q;

   always_comb begin
      unique case (PADDR)
         PORTD_FUNCTION_SELECT_OFFS, PORTD_DIRECTION_OFFS, PORTD_DATA_OFFS,
         PORTE_FUNCTION_SELECT_OFFS, PORTE_DIRECTION_OFFS, PORTE_DATA_OFFS,
         SYNC_CLOCK_STATUS_OFFS: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   // ==========================================
   // APB register file, one wait state: answer on second access edge
   always_comb begin
      d_func_d = d_func_q;
      d_dir_d = d_dir_q;
      d_data_d = d_data_q;
      e_func_d = e_func_q;
      e_dir_d = e_dir_q;
      e_data_d = e_data_q;
      prdata_d = prdata_q;
      pready_d = 1'b0;
      pslverr_d = 1'b0;
      if (access) begin
         pready_d = 1'b1;
         pslverr_d = !mapped;
         prdata_d = 32'h0000_0000;
         if (PWRITE) begin
            unique case (PADDR)
               PORTD_FUNCTION_SELECT_OFFS: d_func_d = PWDATA[PORTD_WIDTH-1:0];
               PORTD_DIRECTION_OFFS: d_dir_d = PWDATA[PORTD_WIDTH-1:0];
               PORTD_DATA_OFFS: d_data_d = PWDATA[PORTD_WIDTH-1:0];
               PORTE_FUNCTION_SELECT_OFFS: e_func_d = PWDATA[PORTE_WIDTH-1:0];
               PORTE_DIRECTION_OFFS: e_dir_d = PWDATA[PORTE_WIDTH-1:0];
               PORTE_DATA_OFFS: e_data_d = PWDATA[PORTE_WIDTH-1:0];
               default: ;
            endcase
         end else begin
            unique case (PADDR)
               PORTD_FUNCTION_SELECT_OFFS: prdata_d[PORTD_WIDTH-1:0] = d_func_q;
               PORTD_DIRECTION_OFFS: prdata_d[PORTD_WIDTH-1:0] = d_dir_q;
               PORTD_DATA_OFFS: prdata_d[PORTD_WIDTH-1:0] = d_level;
               PORTE_FUNCTION_SELECT_OFFS: prdata_d[PORTE_WIDTH-1:0] = e_func_q;
               PORTE_DIRECTION_OFFS: prdata_d[PORTE_WIDTH-1:0] = e_dir_q;
               PORTE_DATA_OFFS: prdata_d[PORTE_WIDTH-1:0] = e_level;
               SYNC_CLOCK_STATUS_OFFS: prdata_d[0] = short_half_q;
               default: ;
            endcase
         end
      end
   end

   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         d_func_q <= PORTD_RESET;
         d_dir_q <= PORTD_RESET;
         d_data_q <= PORTD_RESET;
         e_func_q <= PORTE_RESET;
         e_dir_q <= PORTE_RESET;
         e_data_q <= PORTE_RESET;
         prdata_q <= 32'h0000_0000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         d_func_q <= d_func_d;
         d_dir_q <= d_dir_d;
         d_data_q <= d_data_d;
         e_func_q <= e_func_d;
         e_dir_q <= e_dir_d;
         e_data_q <= e_data_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
      end
   end

   assign PRDATA = prdata_q;
   assign PREADY = pready_q;
   assign PSLVERR = pslverr_q;

   // ==========================================
   // Peripheral drive per pin
   always_comb begin
      d_per_out = '0;
      d_per_oe = '0;
      d_per_out[SYNC_CLOCK_BIT] = SYNC_DRIVE.sck_out;
      d_per_oe[SYNC_CLOCK_BIT] = SYNC_DRIVE.sck_oe;
      d_per_oe[SYNC_RX_BIT] = 1'b0;
      d_per_out[SYNC_TX_BIT] = SYNC_DRIVE.tx_data;
      d_per_oe[SYNC_TX_BIT] = SYNC_DRIVE.tx_active;
      e_per_out = '0;
      e_per_oe = '0;
      e_per_oe[ASYNC_RX_BIT] = 1'b0;
      e_per_out[ASYNC_TX_BIT] = ASYNC_DRIVE.tx_data;
      e_per_oe[ASYNC_TX_BIT] = 1'b1;
      e_per_out[ASYNC_CLOCK_BIT] = ASYNC_DRIVE.clk_out;
      e_per_oe[ASYNC_CLOCK_BIT] = ASYNC_DRIVE.clk_oe;
   end

   // ==========================================
   // Pin cells
   for (genvar i = 0; i < PORTD_WIDTH; i++) begin : g_portd
      pin_cell u_cell (
         .clk(REF_CLK),
         .arst_n(ARST_N),
         .func_sel(d_func_q[i]),
         .gpio_dir(d_dir_q[i]),
         .gpio_out(d_data_q[i]),
         .periph_out(d_per_out[i]),
         .periph_oe(d_per_oe[i]),
         .pin_in(PORTD_IN[i]),
         .pin_out(PORTD_OUT[i]),
         .pin_oe(PORTD_OE[i]),
         .pin_level(d_level[i])
      );
   end
   for (genvar i = 0; i < PORTE_WIDTH; i++) begin : g_porte
      pin_cell u_cell (
         .clk(REF_CLK),
         .arst_n(ARST_N),
         .func_sel(e_func_q[i]),
         .gpio_dir(e_dir_q[i]),
         .gpio_out(e_data_q[i]),
         .periph_out(e_per_out[i]),
         .periph_oe(e_per_oe[i]),
         .pin_in(PORTE_IN[i]),
         .pin_out(PORTE_OUT[i]),
         .pin_oe(PORTE_OE[i]),
         .pin_level(e_level[i])
      );
   end

   // Sense outputs are held low while the pin belongs to GPIO
   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         SYNC_SENSE <= '0;
         ASYNC_SENSE <= '0;
      end else begin
         SYNC_SENSE.sck_in <= d_func_q[SYNC_CLOCK_BIT] & d_level[SYNC_CLOCK_BIT];
         SYNC_SENSE.rx_data <= d_func_q[SYNC_RX_BIT] & d_level[SYNC_RX_BIT];
         ASYNC_SENSE.rx_data <= e_func_q[ASYNC_RX_BIT] & e_level[ASYNC_RX_BIT];
         ASYNC_SENSE.clk_in <= e_func_q[ASYNC_CLOCK_BIT] & e_level[ASYNC_CLOCK_BIT];
      end
   end

   // ==========================================
   // External sync clock check: sticky flag on a half shorter than allowed.
   // Only a monitor; the clock is still passed on, software decides.
   always_comb begin
      sck_prev_d = d_level[SYNC_CLOCK_BIT];
      half_cnt_d = half_cnt_q;
      short_half_d = short_half_q;
      if (sck_prev_q != d_level[SYNC_CLOCK_BIT]) begin
         half_cnt_d = 3'd1;
         if (d_func_q[SYNC_CLOCK_BIT] && !SYNC_DRIVE.sck_oe &&
             half_cnt_q < HALF_COUNT_WIDTH'(SYNC_CLOCK_MIN_HALF_CYC)) begin
            short_half_d = 1'b1;
         end
      end else if (half_cnt_q != 3'h7) begin
         half_cnt_d = half_cnt_q + 3'd1;
      end
      if (access && !PWRITE && PADDR == SYNC_CLOCK_STATUS_OFFS) begin
         short_half_d = 1'b0;
      end
      if (sck_prev_q != d_level[SYNC_CLOCK_BIT] && d_func_q[SYNC_CLOCK_BIT] &&
          !SYNC_DRIVE.sck_oe &&
          half_cnt_q < HALF_COUNT_WIDTH'(SYNC_CLOCK_MIN_HALF_CYC)) begin
         short_half_d = 1'b1;
      end
   end

   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         sck_prev_q <= 1'b0;
         half_cnt_q <= 3'h7;
         short_half_q <= 1'b0;
      end else begin
         sck_prev_q <= sck_prev_d;
         half_cnt_q <= half_cnt_d;
         short_half_q <= short_half_d;
      end
   end

   // ==========================================
   // Checks
   chk_reset_inputs: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
      $rose(ARST_N) |-> (d_func_q == '0 && e_func_q == '0))
      else $error("Pins not GPIO after reset");
   chk_portd_gpio_dir: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
      (!d_func_q[0] && $stable(d_func_q) && $stable(d_dir_q)) |=>
      (PORTD_OE[0] == $past(d_dir_q[0])))
      else $error("Port D GPIO direction wrong");
   chk_porte_gpio_dir: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
      (!e_func_q[1] && $stable(e_func_q) && $stable(e_dir_q)) |=>
      (PORTE_OE[1] == $past(e_dir_q[1])))
      else $error("Port E GPIO direction wrong");
   chk_sync_tx_drive: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
      (d_func_q[SYNC_TX_BIT] && $stable(d_func_q)) |=>
      (PORTD_OE[SYNC_TX_BIT] == $past(SYNC_DRIVE.tx_active)))
      else $error("Sync transmit pin drive wrong");
   chk_sync_rx_input: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
      (d_func_q[SYNC_RX_BIT] && $stable(d_func_q)) |=> !PORTD_OE[SYNC_RX_BIT])
      else $error("Sync receive pin driven");
   chk_async_tx_drive: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
      (e_func_q[ASYNC_TX_BIT] && $stable(e_func_q)) |=>
      (PORTE_OE[ASYNC_TX_BIT] && PORTE_OUT[ASYNC_TX_BIT] == $past(ASYNC_DRIVE.tx_data)))
      else $error("Async transmit pin wrong");
   chk_async_clk_dir: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
      (e_func_q[ASYNC_CLOCK_BIT] && $stable(e_func_q)) |=>
      (PORTE_OE[ASYNC_CLOCK_BIT] == $past(ASYNC_DRIVE.clk_oe)))
      else $error("Async clock direction wrong");
   chk_sync_clk_dir: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
      (d_func_q[SYNC_CLOCK_BIT] && $stable(d_func_q)) |=>
      (PORTD_OE[SYNC_CLOCK_BIT] == $past(SYNC_DRIVE.sck_oe)))
      else $error("Sync clock direction wrong");
   chk_apb_answer: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
      (PSEL && PENABLE && !PREADY) |=> PREADY)
      else $error("APB answer late");
   cov_sync_func: cover property (@(posedge REF_CLK) disable iff (!ARST_N)
      d_func_q[SYNC_TX_BIT] && PORTD_OE[SYNC_TX_BIT]);
   cov_async_func: cover property (@(posedge REF_CLK) disable iff (!ARST_N)
      e_func_q[ASYNC_TX_BIT] && PORTE_OE[ASYNC_TX_BIT]);
   cov_short_half: cover property (@(posedge REF_CLK) disable iff (!ARST_N)
      $rose(short_half_q));
endmodule : serial_pin_mux

// File: logic/serial_pin_mux_pkg.sv
// Constants and types for the serial-port pin multiplexer.
// Assumes an APB master on REF_CLK (10 MHz) and pins sampled by two flops.
// How it works
// - Port D bits 3 to 5 come up as general-purpose inputs after reset.
// - A port D pin in general-purpose mode drives per its direction bit.
// - Port D function bit set on bits 3 to 5 hands the pin to the synchronous serial port.
// - Port E bits 0 to 2 come up as general-purpose inputs after reset.
// - A port E pin in general-purpose mode drives per its direction bit.
// - Port E function bit set hands the pin to the asynchronous serial port.
// - Sync serial clock pin may be input or output, chosen by the peripheral.
// - Sync receive pin is an input and feeds the receive shift register.
// - Sync transmit pin drives only while the peripheral transmits.
// - Async receive pin carries serial data into the async receiver.
// - Async transmit pin outputs data from the async transmitter.
// - Async clock pin is bidirectional: accepts or supplies the clock.
// - Port D bits 0 to 2 also reset to inputs and share port D registers.
package serial_pin_mux_pkg;
   // ==========================================
   // Register map (byte addresses)
   localparam logic [11:0] PORTD_FUNCTION_SELECT_OFFS = 12'h000;
   localparam logic [11:0] PORTD_DIRECTION_OFFS = 12'h004;
   localparam logic [11:0] PORTD_DATA_OFFS = 12'h008;
   localparam logic [11:0] PORTE_FUNCTION_SELECT_OFFS = 12'h00c;
   localparam logic [11:0] PORTE_DIRECTION_OFFS = 12'h010;
   localparam logic [11:0] PORTE_DATA_OFFS = 12'h014;
   localparam logic [11:0] SYNC_CLOCK_STATUS_OFFS = 12'h018;
   // ==========================================
   // Widths and reset values
   localparam int PORTD_WIDTH = 6;
   localparam int PORTE_WIDTH = 3;
   localparam logic [5:0] PORTD_RESET = 6'h00;
   localparam logic [2:0] PORTE_RESET = 3'h0;
   // Port D bit positions of the synchronous port pins
   localparam int SYNC_CLOCK_BIT = 3;
   localparam int SYNC_RX_BIT = 4;
   localparam int SYNC_TX_BIT = 5;
   // Port E bit positions of the asynchronous port pins
   localparam int ASYNC_RX_BIT = 0;
   localparam int ASYNC_TX_BIT = 1;
   localparam int ASYNC_CLOCK_BIT = 2;
   // ==========================================
   // Link clock timing: least half period, three system clocks
   localparam int REF_CLK_PERIOD_NS = 100;
   localparam int SYNC_CLOCK_MIN_HALF_NS = 300;
   localparam int SYNC_CLOCK_MIN_HALF_CYC =
      (SYNC_CLOCK_MIN_HALF_NS + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;
   localparam int HALF_COUNT_WIDTH = 3;
   // ==========================================
   // Peripheral-side signal groups
   typedef struct packed {
      logic sck_out;
      logic sck_oe;
      logic tx_data;
      logic tx_active;
   } sync_port_drive_type;
   typedef struct packed {
      logic sck_in;
      logic rx_data;
   } sync_port_sense_type;
   typedef struct packed {
      logic tx_data;
      logic clk_out;
      logic clk_oe;
   } async_port_drive_type;
   typedef struct packed {
      logic rx_data;
      logic clk_in;
   } async_port_sense_type;
endpackage : serial_pin_mux_pkg

// File: tb/serial_far_end.sv
// Far-end serial devices on ports D and E: fixed levels and a link clock.
// Assumes the bench steers it; it merges its drive with the block's drive.
`timescale 1ns/100ps
module serial_far_end
   import serial_pin_mux_pkg::*;
(
   // Control from the bench
   input wire logic run,
   input wire logic fast,
   input wire logic [PORTD_WIDTH-1:0] lvl_d,
   input wire logic [PORTE_WIDTH-1:0] lvl_e,
   // Block side of the pins
   input wire logic [PORTD_WIDTH-1:0] dut_out_d,
   input wire logic [PORTD_WIDTH-1:0] dut_oe_d,
   input wire logic [PORTE_WIDTH-1:0] dut_out_e,
   input wire logic [PORTE_WIDTH-1:0] dut_oe_e,
   // Resolved wire levels
   output logic [PORTD_WIDTH-1:0] pin_d,
   output logic [PORTE_WIDTH-1:0] pin_e
);
   logic sck;
   logic [PORTD_WIDTH-1:0] ext_d;
   // ==========================================
   // Link clock
   // Stands low between runs; odd offset keeps edges off system clock edges
   // Fast mode breaks the slow-clock limit on purpose, for the fault test
   always begin
      if (run) begin
         #(fast ? 200 : 400);
         sck = ~sck;
      end else begin
         sck = 1'b0;
         @(posedge run);
         #37;
      end
   end
   // ==========================================
   // Wire resolution
   always_comb begin
      ext_d = lvl_d;
      ext_d[SYNC_CLOCK_BIT] = run ? sck : lvl_d[SYNC_CLOCK_BIT];
   end
   assign pin_d = (dut_oe_d & dut_out_d) | (~dut_oe_d & ext_d);
   assign pin_e = (dut_oe_e & dut_out_e) | (~dut_oe_e & lvl_e);
endmodule : serial_far_end

// File: tb/testbench.sv
// Self-checking bench for the serial pin multiplexer.
// Assumes APB on REF_CLK and the far-end model on the port pins.
`timescale 1ns/100ps
module testbench
   import serial_pin_mux_pkg::*;
;
   typedef struct packed {
      logic [5:0] fd, dd, od;
      logic [2:0] fe, de, oe;
      sync_port_drive_type sd;
      async_port_drive_type ad;
      logic [5:0] xdoe, xdout;
      logic [2:0] xeoe, xeout;
   } row_type;
   row_type rows [4] = '{
      '{6'h00, 6'h3f, 6'h2a, 3'h0, 3'h7, 3'h5, 4'h0, 3'h0, 6'h3f, 6'h2a, 3'h7, 3'h5},
      '{6'h38, 6'h3f, 6'h3f, 3'h7, 3'h0, 3'h0, 4'hd, 3'h5, 6'h2f, 6'h0f, 3'h6, 3'h2},
      '{6'h3f, 6'h3f, 6'h00, 3'h7, 3'h7, 3'h7, 4'h0, 3'h0, 6'h00, 6'h00, 3'h2, 3'h0},
      '{6'h20, 6'h00, 6'h3f, 3'h0, 3'h2, 3'h2, 4'h3, 3'h0, 6'h20, 6'h20, 3'h2, 3'h2}};
   logic REF_CLK = 1'b0, ARST_N = 1'b0;
   logic PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
   logic [11:0] PADDR = 12'h000;
   logic [31:0] PWDATA = 32'h0, PRDATA;
   logic PREADY, PSLVERR, run = 1'b0, fast = 1'b0, e;
   logic [5:0] PORTD_IN, PORTD_OUT, PORTD_OE, lvl_d = 6'h00;
   logic [2:0] PORTE_IN, PORTE_OUT, PORTE_OE, lvl_e = 3'h0;
   sync_port_drive_type SYNC_DRIVE = '0;
   sync_port_sense_type SYNC_SENSE;
   async_port_drive_type ASYNC_DRIVE = '0;
   async_port_sense_type ASYNC_SENSE;
   logic [31:0] r;
   logic prev;
   int err_total = 0, n_tests = 0, cnt;
   always #50 REF_CLK = ~REF_CLK;
   serial_pin_mux u_dut (.REF_CLK(REF_CLK), .ARST_N(ARST_N), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
      .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .PORTD_IN(PORTD_IN),
      .PORTD_OUT(PORTD_OUT), .PORTD_OE(PORTD_OE), .PORTE_IN(PORTE_IN),
      .PORTE_OUT(PORTE_OUT), .PORTE_OE(PORTE_OE), .SYNC_DRIVE(SYNC_DRIVE),
      .SYNC_SENSE(SYNC_SENSE), .ASYNC_DRIVE(ASYNC_DRIVE), .ASYNC_SENSE(ASYNC_SENSE));
   serial_far_end u_far (.run(run), .fast(fast), .lvl_d(lvl_d), .lvl_e(lvl_e),
      .dut_out_d(PORTD_OUT), .dut_oe_d(PORTD_OE), .dut_out_e(PORTE_OUT),
      .dut_oe_e(PORTE_OE), .pin_d(PORTD_IN), .pin_e(PORTE_IN));
   // ==========================================
   // Shared tasks
   task results();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : results
   task check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   // Request held until the edge that samples PREADY high
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
            output logic [31:0] rd, output logic err);
      int i;
      @(posedge REF_CLK);
      PSEL <= 1'b1;
      PWRITE <= wr;
      PADDR <= a;
      PWDATA <= wd;
      @(posedge REF_CLK);
      PENABLE <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge REF_CLK);
         if (PREADY === 1'b1) break;
      end
      if (i == 20) begin
         err_total++;
         results();
      end
      rd = PRDATA;
      err = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask : apb
   task wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] x;
      logic y;
      apb(1'b1, a, d, x, y);
   endtask : wr
   task rd(input logic [11:0] a, output logic [31:0] d);
      logic y;
      apb(1'b0, a, 32'h0, d, y);
   endtask : rd
   task reset_check();
      check({PORTD_OE, PORTE_OE}, 32'h0);
      rd(PORTD_FUNCTION_SELECT_OFFS, r);
      check(r, 32'h0);
      rd(PORTE_DIRECTION_OFFS, r);
      check(r, 32'h0);
   endtask : reset_check
   // ==========================================
   // Main sequence
   initial begin
      repeat (3) @(posedge REF_CLK);
      ARST_N <= 1'b1;
      reset_check();
      foreach (rows[k]) begin
         SYNC_DRIVE <= rows[k].sd;
         ASYNC_DRIVE <= rows[k].ad;
         wr(PORTD_DIRECTION_OFFS, 32'(rows[k].dd));
         wr(PORTD_DATA_OFFS, 32'(rows[k].od));
         wr(PORTD_FUNCTION_SELECT_OFFS, 32'(rows[k].fd));
         wr(PORTE_DIRECTION_OFFS, 32'(rows[k].de));
         wr(PORTE_DATA_OFFS, 32'(rows[k].oe));
         wr(PORTE_FUNCTION_SELECT_OFFS, 32'(rows[k].fe));
         repeat (2) @(posedge REF_CLK);
         check(PORTD_OE, rows[k].xdoe);
         check(PORTD_OUT & rows[k].xdoe, rows[k].xdout);
         check(PORTE_OE, rows[k].xeoe);
         check(PORTE_OUT & rows[k].xeoe, rows[k].xeout);
      end
      rd(PORTE_DIRECTION_OFFS, r);
      check(r, 32'h2);
      apb(1'b0, 12'h01c, 32'h0, r, e);
      check(r, 32'h0);
      check(e, 1'b1);
      // Second reset in mid-run, off the clock edge
      #20 ARST_N = 1'b0;
      #1 check({PORTD_OE, PORTE_OE}, 32'h0);
      repeat (3) @(posedge REF_CLK);
      ARST_N <= 1'b1;
      reset_check();
      // Pin levels seen through the data register and the engine sense ports
      SYNC_DRIVE <= '0;
      ASYNC_DRIVE <= '0;
      lvl_d <= 6'h15;
      repeat (4) @(posedge REF_CLK);
      rd(PORTD_DATA_OFFS, r);
      check(r, 32'h15);
      check(SYNC_SENSE, 2'b00);
      wr(PORTD_FUNCTION_SELECT_OFFS, 32'h18);
      wr(PORTE_FUNCTION_SELECT_OFFS, 32'h5);
      for (int v = 0; v < 2; v++) begin
         lvl_d <= v ? 6'h18 : 6'h00;
         lvl_e <= v ? 3'h5 : 3'h0;
         repeat (5) @(posedge REF_CLK);
         check(SYNC_SENSE, {2{v[0]}});
         check(ASYNC_SENSE, {2{v[0]}});
      end
      // Slow link clock: sixteen periods in the window, no short half
      lvl_d <= 6'h00;
      run <= 1'b1;
      repeat (20) @(posedge REF_CLK);
      rd(SYNC_CLOCK_STATUS_OFFS, r);
      cnt = 0;
      prev = SYNC_SENSE.sck_in;
      repeat (128) begin
         @(posedge REF_CLK);
         if (SYNC_SENSE.sck_in === 1'b1 && prev === 1'b0) cnt++;
         prev = SYNC_SENSE.sck_in;
      end
      check(cnt >= 15 && cnt <= 17, 1'b1);
      rd(SYNC_CLOCK_STATUS_OFFS, r);
      check(r, 32'h0);
      // Too fast a link clock is flagged, and reading clears the flag
      fast <= 1'b1;
      repeat (40) @(posedge REF_CLK);
      run <= 1'b0;
      fast <= 1'b0;
      repeat (10) @(posedge REF_CLK);
      rd(SYNC_CLOCK_STATUS_OFFS, r);
      check(r, 32'h1);
      rd(SYNC_CLOCK_STATUS_OFFS, r);
      check(r, 32'h0);
      results();
   end
endmodule : testbench
